// >>> sls_pkg.sv
// Constants shared by the serial lane status register bank
package sls_pkg;

  // Number of links that the page selector chooses between
  localparam int unsigned NUM_LINKS = 2;
  // Error event kinds counted per link: lane 2 then lane 3
  localparam int unsigned NUM_ERR = 6;
  localparam int unsigned ERR_L2_DISPARITY = 0;
  localparam int unsigned ERR_L2_NOT_IN_TABLE = 1;
  localparam int unsigned ERR_L2_UNEXP_CTRL = 2;
  localparam int unsigned ERR_L3_DISPARITY = 3;
  localparam int unsigned ERR_L3_NOT_IN_TABLE = 4;
  localparam int unsigned ERR_L3_UNEXP_CTRL = 5;

  // Bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_LINK_PAGE = 16'h0300;
  localparam logic [ADDR_W-1:0] IDX_THRESHOLD = 16'h0301;
  localparam logic [ADDR_W-1:0] IDX_CNT_CTRL = 16'h0302;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 16'h0303;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 16'h0304;
  localparam logic [ADDR_W-1:0] IDX_LANE2_STATUS = 16'h04b2;
  localparam logic [ADDR_W-1:0] IDX_LANE3_STATUS = 16'h04b3;

  // Status byte field positions
  localparam int unsigned BIT_DISPARITY = 7;
  localparam int unsigned BIT_NOT_IN_TABLE = 6;
  localparam int unsigned BIT_UNEXP_CTRL = 5;
  localparam int unsigned BIT_DESKEW = 4;
  localparam int unsigned BIT_INIT_SYNC = 3;
  localparam int unsigned BIT_CHECKSUM = 2;
  localparam int unsigned BIT_FRAME_SYNC = 1;
  localparam int unsigned BIT_CGS = 0;

  // Control and interrupt field positions
  localparam int unsigned BIT_CNT_CLEAR = 0;
  localparam int unsigned IRQ_PER_LINK = 8;
  localparam int unsigned IRQ_W = 16;
  localparam int unsigned IRQ_CGS_LOST = 6;
  localparam int unsigned IRQ_FS_LOST = 7;

  // Reset values
  localparam logic RST_LINK_PAGE = 1'b0;
  localparam logic [CNT_W-1:0] RST_THRESHOLD = 8'hff;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ_STATUS = 16'h0000;
  localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;

  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// >>> sls_err_cnt.sv
// Saturating error counter with threshold comparison for one lane error kind
`timescale 1ns/1ps
module sls_err_cnt (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic inc,
  input wire logic [sls_pkg::CNT_W-1:0] threshold,
  output logic at_or_above
);

  logic [sls_pkg::CNT_W-1:0] cnt_q;
  logic [sls_pkg::CNT_W-1:0] cnt_d;
  logic sat;

  // Saturate rather than wrap, so a long burst never reads as below threshold
  assign sat = &cnt_q;
  assign cnt_d = clr ? sls_pkg::RST_COUNT : ((inc && !sat) ? cnt_q + 8'h01 : cnt_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= sls_pkg::RST_COUNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign at_or_above = (cnt_q >= threshold);

endmodule // sls_err_cnt

// >>> sls_top.sv
// Lane 2 and lane 3 link status register bank with AXI4-Lite access
//
// How it works
// - Lane2 bit7: disparity count at/above threshold
// - Lane2 bit6: not-in-table count at/above threshold
// - Lane2 bit5: unexpected control count at/above threshold
// - Lane2 bit4: deskew achieved is one
// - Lane2 bit3: initial lane sync achieved
// - Lane2 bit2: received checksum correct
// - Lane2 bit1: frame sync held
// - Lane2 bit0: code group sync achieved
// - Lane3 bits7..5: same three threshold comparisons
// - Link page selector chooses which link reads
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module sls_top (
  input wire logic CLK,
  input wire logic RSTN,
  // AXI4-Lite slave
  input wire logic [sls_pkg::ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [sls_pkg::DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [sls_pkg::ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [sls_pkg::DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Lane receiver, one bit per link, same clock
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_DISPARITY_ERR,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_NOT_IN_TABLE_ERR,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_UNEXPECTED_CTRL_ERR,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE3_DISPARITY_ERR,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE3_NOT_IN_TABLE_ERR,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE3_UNEXPECTED_CTRL_ERR,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_DESKEW_OK,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_INITIAL_SYNC_OK,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_CHECKSUM_OK,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_FRAME_SYNC_OK,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_CODE_GROUP_SYNC_OK,
  // Interrupt
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int unsigned NL = sls_pkg::NUM_LINKS;
  localparam int unsigned NE = sls_pkg::NUM_ERR;

  logic aw_have_q;
  logic [sls_pkg::ADDR_W-1:0] awaddr_q;
  logic w_have_q;
  logic [sls_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [sls_pkg::DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;

  logic link_page_q;
  logic [sls_pkg::CNT_W-1:0] error_count_threshold_q;
  logic [sls_pkg::IRQ_W-1:0] irq_status_q;
  logic [sls_pkg::IRQ_W-1:0] irq_status_d;
  logic [sls_pkg::IRQ_W-1:0] irq_mask_q;
  logic irq_q;

  logic [NE-1:0] err_ev [NL];
  logic [NE-1:0] err_flag [NL];
  logic [NE-1:0] err_flag_q [NL];
  logic [NL-1:0] cgs_q;
  logic [NL-1:0] fs_q;
  logic [7:0] lane2_link_status [NL];
  logic [7:0] lane3_link_status [NL];
  logic [sls_pkg::IRQ_W-1:0] irq_event;

  logic aw_fire;
  logic w_fire;
  logic aw_ok;
  logic w_ok;
  logic wr_do;
  logic [sls_pkg::ADDR_W-1:0] wr_addr;
  logic [sls_pkg::DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [sls_pkg::IRQ_W-1:0] wr_mask16;
  logic wr_page;
  logic wr_thresh;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;
  logic wr_ro;
  logic wr_hit;
  logic cnt_clear;
  logic [sls_pkg::IRQ_W-1:0] irq_clear;

  logic ar_fire;
  logic rd_page;
  logic rd_thresh;
  logic rd_ctrl;
  logic rd_istat;
  logic rd_imask;
  logic rd_lane2;
  logic rd_lane3;
  logic rd_hit;
  logic [sls_pkg::DATA_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order

  assign AWREADY = !aw_have_q && !bvalid_q;
  assign WREADY = !w_have_q && !bvalid_q;
  assign aw_fire = AWVALID && AWREADY;
  assign w_fire = WVALID && WREADY;
  assign aw_ok = aw_have_q || aw_fire;
  assign w_ok = w_have_q || w_fire;
  assign wr_do = aw_ok && w_ok;
  assign wr_addr = aw_have_q ? awaddr_q : AWADDR;
  assign wr_data = w_have_q ? wdata_q : WDATA;
  assign wr_strb = w_have_q ? wstrb_q : WSTRB;
  assign wr_mask16 = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  assign wr_page = (wr_addr == {sls_pkg::IDX_LINK_PAGE[13:0], 2'b00});
  assign wr_thresh = (wr_addr == {sls_pkg::IDX_THRESHOLD[13:0], 2'b00});
  assign wr_ctrl = (wr_addr == {sls_pkg::IDX_CNT_CTRL[13:0], 2'b00});
  assign wr_istat = (wr_addr == {sls_pkg::IDX_IRQ_STATUS[13:0], 2'b00});
  assign wr_imask = (wr_addr == {sls_pkg::IDX_IRQ_MASK[13:0], 2'b00});
  // Status registers accept the write with OKAY and store nothing
  assign wr_ro = (wr_addr == {sls_pkg::IDX_LANE2_STATUS[13:0], 2'b00}) ||
                 (wr_addr == {sls_pkg::IDX_LANE3_STATUS[13:0], 2'b00});
  assign wr_hit = wr_page || wr_thresh || wr_ctrl || wr_istat || wr_imask || wr_ro;

  assign cnt_clear = wr_do && wr_ctrl && wr_strb[0] && wr_data[sls_pkg::BIT_CNT_CLEAR];
  assign irq_clear = (wr_do && wr_istat) ? (wr_data[sls_pkg::IRQ_W-1:0] & wr_mask16) : '0;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else begin
      if (aw_fire && !wr_do) begin
        aw_have_q <= 1'b1;
        awaddr_q <= AWADDR;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (w_fire && !wr_do) begin
        w_have_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bvalid_q <= 1'b0;
      bresp_q <= sls_pkg::RESP_OKAY;
    end else begin
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? sls_pkg::RESP_OKAY : sls_pkg::RESP_DECERR;
      end else if (BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      link_page_q <= sls_pkg::RST_LINK_PAGE;
      error_count_threshold_q <= sls_pkg::RST_THRESHOLD;
      irq_mask_q <= sls_pkg::RST_IRQ_MASK;
    end else begin
      if (wr_do && wr_page && wr_strb[0]) begin
        link_page_q <= wr_data[0];
      end
      if (wr_do && wr_thresh && wr_strb[0]) begin
        error_count_threshold_q <= wr_data[7:0];
      end
      if (wr_do && wr_imask) begin
        irq_mask_q <= (irq_mask_q & ~wr_mask16) | (wr_data[sls_pkg::IRQ_W-1:0] & wr_mask16);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-link error counters and status bytes

  genvar gl;
  genvar ge;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_link
      assign err_ev[gl][sls_pkg::ERR_L2_DISPARITY] = LANE2_DISPARITY_ERR[gl];
      assign err_ev[gl][sls_pkg::ERR_L2_NOT_IN_TABLE] = LANE2_NOT_IN_TABLE_ERR[gl];
      assign err_ev[gl][sls_pkg::ERR_L2_UNEXP_CTRL] = LANE2_UNEXPECTED_CTRL_ERR[gl];
      assign err_ev[gl][sls_pkg::ERR_L3_DISPARITY] = LANE3_DISPARITY_ERR[gl];
      assign err_ev[gl][sls_pkg::ERR_L3_NOT_IN_TABLE] = LANE3_NOT_IN_TABLE_ERR[gl];
      assign err_ev[gl][sls_pkg::ERR_L3_UNEXP_CTRL] = LANE3_UNEXPECTED_CTRL_ERR[gl];

      for (ge = 0; ge < NE; ge++) begin : g_err
        // Counts compared with one shared threshold
        sls_err_cnt u_cnt (
          .clk(CLK),
          .rstn(RSTN),
          .clr(cnt_clear),
          .inc(err_ev[gl][ge]),
          .threshold(error_count_threshold_q),
          .at_or_above(err_flag[gl][ge])
        );
      end

      logic lane2_disparity_err_flag;
      logic lane2_not_in_table_flag;
      logic lane2_unexpected_ctrl_flag;
      logic lane3_disparity_err_flag;
      logic lane3_not_in_table_flag;
      logic lane3_unexpected_ctrl_flag;
      assign lane2_disparity_err_flag = err_flag[gl][sls_pkg::ERR_L2_DISPARITY];
      assign lane2_not_in_table_flag = err_flag[gl][sls_pkg::ERR_L2_NOT_IN_TABLE];
      assign lane2_unexpected_ctrl_flag = err_flag[gl][sls_pkg::ERR_L2_UNEXP_CTRL];
      assign lane3_disparity_err_flag = err_flag[gl][sls_pkg::ERR_L3_DISPARITY];
      assign lane3_not_in_table_flag = err_flag[gl][sls_pkg::ERR_L3_NOT_IN_TABLE];
      assign lane3_unexpected_ctrl_flag = err_flag[gl][sls_pkg::ERR_L3_UNEXP_CTRL];

      always_comb begin
        lane2_link_status[gl] = 8'h00;
        lane2_link_status[gl][sls_pkg::BIT_DISPARITY] = lane2_disparity_err_flag;
        lane2_link_status[gl][sls_pkg::BIT_NOT_IN_TABLE] = lane2_not_in_table_flag;
        lane2_link_status[gl][sls_pkg::BIT_UNEXP_CTRL] = lane2_unexpected_ctrl_flag;
        lane2_link_status[gl][sls_pkg::BIT_DESKEW] = LANE2_DESKEW_OK[gl];
        lane2_link_status[gl][sls_pkg::BIT_INIT_SYNC] = LANE2_INITIAL_SYNC_OK[gl];
        lane2_link_status[gl][sls_pkg::BIT_CHECKSUM] = LANE2_CHECKSUM_OK[gl];
        lane2_link_status[gl][sls_pkg::BIT_FRAME_SYNC] = LANE2_FRAME_SYNC_OK[gl];
        lane2_link_status[gl][sls_pkg::BIT_CGS] = LANE2_CODE_GROUP_SYNC_OK[gl];
      end

      // Lane 3 low bits are not carried by this bank and read zero
      always_comb begin
        lane3_link_status[gl] = 8'h00;
        lane3_link_status[gl][sls_pkg::BIT_DISPARITY] = lane3_disparity_err_flag;
        lane3_link_status[gl][sls_pkg::BIT_NOT_IN_TABLE] = lane3_not_in_table_flag;
        lane3_link_status[gl][sls_pkg::BIT_UNEXP_CTRL] = lane3_unexpected_ctrl_flag;
      end

      // Events: a flag crossing upward, or lane 2 losing sync
      assign irq_event[gl*sls_pkg::IRQ_PER_LINK +: NE] = err_flag[gl] & ~err_flag_q[gl];
      assign irq_event[gl*sls_pkg::IRQ_PER_LINK + sls_pkg::IRQ_CGS_LOST] =
        cgs_q[gl] & ~LANE2_CODE_GROUP_SYNC_OK[gl];
      assign irq_event[gl*sls_pkg::IRQ_PER_LINK + sls_pkg::IRQ_FS_LOST] =
        fs_q[gl] & ~LANE2_FRAME_SYNC_OK[gl];

      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          err_flag_q[gl] <= '0;
          cgs_q[gl] <= 1'b0;
          fs_q[gl] <= 1'b0;
        end else begin
          err_flag_q[gl] <= err_flag[gl];
          cgs_q[gl] <= LANE2_CODE_GROUP_SYNC_OK[gl];
          fs_q[gl] <= LANE2_FRAME_SYNC_OK[gl];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  // A new event in the clearing cycle survives the clear
  assign irq_status_d = (irq_status_q & ~irq_clear) | irq_event;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status_q <= sls_pkg::RST_IRQ_STATUS;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one request at a time, data registered

  assign ARREADY = !rvalid_q;
  assign ar_fire = ARVALID && ARREADY;

  assign rd_page = (ARADDR == {sls_pkg::IDX_LINK_PAGE[13:0], 2'b00});
  assign rd_thresh = (ARADDR == {sls_pkg::IDX_THRESHOLD[13:0], 2'b00});
  assign rd_ctrl = (ARADDR == {sls_pkg::IDX_CNT_CTRL[13:0], 2'b00});
  assign rd_istat = (ARADDR == {sls_pkg::IDX_IRQ_STATUS[13:0], 2'b00});
  assign rd_imask = (ARADDR == {sls_pkg::IDX_IRQ_MASK[13:0], 2'b00});
  assign rd_lane2 = (ARADDR == {sls_pkg::IDX_LANE2_STATUS[13:0], 2'b00});
  assign rd_lane3 = (ARADDR == {sls_pkg::IDX_LANE3_STATUS[13:0], 2'b00});
  assign rd_hit = rd_page || rd_thresh || rd_ctrl || rd_istat || rd_imask || rd_lane2 || rd_lane3;

  // Status reads are pure views of live state, nothing changes on a read
  assign rd_mux =
    rd_page ? {31'h0, link_page_q} :
    rd_thresh ? {24'h0, error_count_threshold_q} :
    rd_istat ? {16'h0, irq_status_q} :
    rd_imask ? {16'h0, irq_mask_q} :
    rd_lane2 ? {24'h0, lane2_link_status[link_page_q]} :
    rd_lane3 ? {24'h0, lane3_link_status[link_page_q]} :
    32'h0;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= sls_pkg::RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? sls_pkg::RESP_OKAY : sls_pkg::RESP_DECERR;
      end else if (RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

endmodule // sls_top

// >>> sls_chk.sv
// Checker for the lane status bank ports
`timescale 1ns/1ps
module sls_chk (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [sls_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [sls_pkg::DATA_W-1:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [sls_pkg::NUM_LINKS-1:0] LANE2_CODE_GROUP_SYNC_OK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [15:0] ra_q;
  logic [1:0] cgs_q;
  wire is_l2 = ra_q == (sls_pkg::IDX_LANE2_STATUS << 2);
  wire is_l3 = ra_q == (sls_pkg::IDX_LANE3_STATUS << 2);
  // Capture at the AR edge, which is when the status is sampled
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ra_q <= 16'h0000;
      cgs_q <= 2'h0;
    end else if (ARVALID && ARREADY) begin
      ra_q <= ARADDR;
      cgs_q <= LANE2_CODE_GROUP_SYNC_OK;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_ar_refused: assert property (RVALID |-> !ARREADY) else $error("read accepted while busy");
  a_aw_refused: assert property (BVALID |-> !AWREADY && !WREADY) else $error("write accepted while busy");
  a_read_latency: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
  a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read answer dropped");
  a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID ##1 (BVALID != $past(BREADY)))
    else $error("write answer missing");
  a_status_okay: assert property ($rose(RVALID) && (is_l2 || is_l3) |-> RRESP == sls_pkg::RESP_OKAY
    && RDATA[31:8] == 24'h000000) else $error("status read malformed");
  a_lane3_unused: assert property ($rose(RVALID) && is_l3 |-> RDATA[4:0] == 5'h00)
    else $error("lane3 low bits set");
  a_cgs_level: assert property ($rose(RVALID) && is_l2 && cgs_q[0] == cgs_q[1] |-> RDATA[0] == cgs_q[0])
    else $error("cgs bit wrong");
  c_l2_read: cover property ($rose(RVALID) && is_l2);
  c_l3_flag: cover property ($rose(RVALID) && is_l3 && RDATA[7]);
  c_write: cover property (BVALID && BREADY);
endmodule // sls_chk
bind sls_top sls_chk chk (.CLK, .RSTN, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
  .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .LANE2_CODE_GROUP_SYNC_OK);

// >>> sls_lane_tx.sv
// Lane transmitter stand-in: error pulses and sync levels for two links
`timescale 1ns/1ps
module sls_lane_tx (
  input wire logic clk,
  output logic [1:0] err0, output logic [1:0] err1, output logic [1:0] err2,
  output logic [1:0] err3, output logic [1:0] err4, output logic [1:0] err5,
  output logic [1:0] dsk, output logic [1:0] ils, output logic [1:0] cks,
  output logic [1:0] fs, output logic [1:0] cgs
);
  logic [1:0] err_q [6] = '{default: 2'h0};
  logic [4:0] lvl0_q = 5'h00;
  logic [4:0] lvl1_q = 5'h00;
  assign err0 = err_q[0];
  assign err1 = err_q[1];
  assign err2 = err_q[2];
  assign err3 = err_q[3];
  assign err4 = err_q[4];
  assign err5 = err_q[5];
  assign dsk = {lvl1_q[4], lvl0_q[4]};
  assign ils = {lvl1_q[3], lvl0_q[3]};
  assign cks = {lvl1_q[2], lvl0_q[2]};
  assign fs = {lvl1_q[1], lvl0_q[1]};
  assign cgs = {lvl1_q[0], lvl0_q[0]};
  // Errors arrive back to back, one per high cycle, the hardest case for a counter
  task automatic pulse(input int k, input int link, input int n);
    @(posedge clk);
    err_q[k][link] <= 1'b1;
    repeat (n) @(posedge clk);
    err_q[k][link] <= 1'b0;
  endtask
  task automatic set_lvl(input logic [4:0] l0, input logic [4:0] l1);
    @(posedge clk);
    lvl0_q <= l0;
    lvl1_q <= l1;
  endtask
endmodule // sls_lane_tx

// >>> sls_bench.sv
// Self-checking bench for the lane status register bank
`timescale 1ns/1ps
module sls_bench;
  localparam logic [15:0] A_PAGE = sls_pkg::IDX_LINK_PAGE << 2;
  localparam logic [15:0] A_THR = sls_pkg::IDX_THRESHOLD << 2;
  localparam logic [15:0] A_CTRL = sls_pkg::IDX_CNT_CTRL << 2;
  localparam logic [15:0] A_IST = sls_pkg::IDX_IRQ_STATUS << 2;
  localparam logic [15:0] A_MSK = sls_pkg::IDX_IRQ_MASK << 2;
  localparam logic [15:0] A_L2 = sls_pkg::IDX_LANE2_STATUS << 2;
  localparam logic [15:0] A_L3 = sls_pkg::IDX_LANE3_STATUS << 2;
  logic CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [15:0] AWADDR, ARADDR;
  logic [31:0] WDATA;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [1:0] e0, e1, e2, e3, e4, e5, dsk, ils, cks, fs, cgs;
  int n_mismatch = 0;
  int cmp_count = 0;
  sls_lane_tx tx (.clk(CLK), .err0(e0), .err1(e1), .err2(e2), .err3(e3), .err4(e4), .err5(e5),
    .dsk(dsk), .ils(ils), .cks(cks), .fs(fs), .cgs(cgs));
  sls_top uut (.CLK, .RSTN, .AWADDR, .AWPROT(3'h0), .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf), .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARPROT(3'h0), .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .LANE2_DISPARITY_ERR(e0), .LANE2_NOT_IN_TABLE_ERR(e1), .LANE2_UNEXPECTED_CTRL_ERR(e2),
    .LANE3_DISPARITY_ERR(e3), .LANE3_NOT_IN_TABLE_ERR(e4), .LANE3_UNEXPECTED_CTRL_ERR(e5),
    .LANE2_DESKEW_OK(dsk), .LANE2_INITIAL_SYNC_OK(ils), .LANE2_CHECKSUM_OK(cks),
    .LANE2_FRAME_SYNC_OK(fs), .LANE2_CODE_GROUP_SYNC_OK(cgs), .IRQ);
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail(input string m);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask
  // Handshakes are sampled mid-cycle, where every port is settled
  task automatic axw(input logic [15:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge CLK);
      aw_t = AWVALID && AWREADY;
      w_t = WVALID && WREADY;
      b_t = BVALID && BREADY;
      r = BRESP;
      @(posedge CLK);
      if (aw_t) AWVALID <= 1'b0;
      if (w_t) WVALID <= 1'b0;
      if (b_t) begin
        BREADY <= 1'b0;
        chk({30'h0, r}, {30'h0, sls_pkg::RESP_OKAY}, "write response");
        return;
      end
    end
    fail("write timeout");
    print_verdict();
  endtask
  task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge CLK);
      ar_t = ARVALID && ARREADY;
      r_t = RVALID && RREADY;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      if (ar_t) ARVALID <= 1'b0;
      if (r_t) begin
        RREADY <= 1'b0;
        return;
      end
    end
    fail("read timeout");
    print_verdict();
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axr(A_L2, d, r);
    chk(d, 32'h0, "lane2 reset");
    axr(A_L3, d, r);
    chk(d, 32'h0, "lane3 reset");
    axr(A_THR, d, r);
    chk(d, 32'hff, "threshold reset");
    axw(A_L2, 32'hff);
    axr(A_L2, d, r);
    chk(d, 32'h0, "status write");
    axr(16'h0100, d, r);
    chk({d[29:0], r}, {30'h0, sls_pkg::RESP_DECERR}, "unmapped read");
  endtask
  task automatic t_thresh();
    logic [31:0] d, x2, x3;
    logic [1:0] r;
    x2 = 32'h0;
    x3 = 32'h0;
    axw(A_THR, 32'h3);
    for (int k = 0; k < 6; k++) begin
      tx.pulse(k, 0, 2);
      axr(k < 3 ? A_L2 : A_L3, d, r);
      chk(d, k < 3 ? x2 : x3, "flag below threshold");
      tx.pulse(k, 0, 1);
      if (k < 3) x2[7-k] = 1'b1;
      else x3[10-k] = 1'b1;
      axr(k < 3 ? A_L2 : A_L3, d, r);
      chk(d, k < 3 ? x2 : x3, "flag at threshold");
    end
    axw(A_CTRL, 32'h1);
    axr(A_L2, d, r);
    chk(d, 32'h0, "counters cleared");
  endtask
  task automatic t_page();
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < 2; p++) begin
      tx.set_lvl(p ? 5'h0a : 5'h15, p ? 5'h15 : 5'h0a);
      axr(A_L2, d, r);
      chk(d, p ? 32'h0a : 32'h15, "link0 sync bits");
      axw(A_PAGE, 32'h1);
      axr(A_L2, d, r);
      chk(d, p ? 32'h15 : 32'h0a, "link1 sync bits");
      axw(A_PAGE, 32'h0);
    end
    tx.pulse(0, 1, 3);
    axr(A_L2, d, r);
    chk(d & 32'h80, 32'h0, "link0 flag");
    axw(A_PAGE, 32'h1);
    axr(A_L2, d, r);
    chk(d & 32'h80, 32'h80, "link1 flag");
    axw(A_PAGE, 32'h0);
  endtask
  task automatic wait_irq(input logic e);
    cmp_count++;
    for (int i = 0; i < 20; i++) begin
      @(negedge CLK);
      if (IRQ === e) return;
    end
    fail("irq level timeout");
    print_verdict();
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    tx.set_lvl(5'h1f, 5'h1f);
    axw(A_IST, 32'hffff);
    tx.set_lvl(5'h1d, 5'h1f);
    repeat (4) @(negedge CLK);
    chk({31'h0, IRQ}, 32'h0, "masked irq");
    axr(A_IST, d, r);
    chk(d, 32'h80, "frame sync lost event");
    axw(A_MSK, 32'h80);
    wait_irq(1'b1);
    axw(A_IST, 32'h80);
    wait_irq(1'b0);
    axr(A_IST, d, r);
    chk(d, 32'h0, "status cleared");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    RSTN = 1'b0;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = 16'h0000;
    ARADDR = 16'h0000;
    WDATA = 32'h0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    t_reset();
    t_thresh();
    t_page();
    t_irq();
    print_verdict();
  end
endmodule // sls_bench
